// [core/dpo_bank.sv]
// drive parameter objects: gain set, motor drive flags, analog inputs and their control
// Operation
// - gain subindex 08 is a 32-bit read/write closed-loop torque integral gain resetting to 00002EE0.
// - gain subindex 09 is a 32-bit read/write open-loop torque proportional gain resetting to 0003A980.
// - gain subindex 0A is a 32-bit read/write open-loop torque integral gain resetting to 0000AFC8.
// - subindices 01-02 are position terms, 03-04 speed terms, 05-0A current-controller terms.
// - the drive flag object has count 3 and three signed 8-bit read/write flags resetting to zero.
// - holding flag 0 keeps pwm at 50% duty in switched-on, giving no holding torque.
// - holding flag 1 lets the controller drive pwm in switched-on, holding the motor still.
// - field override 0 uses default direction, 1 forces positive, -1 forces negative.
// - a new field override takes effect only after a control restart, after which setup must rerun.
// - keep-gains 0 makes auto setup detect the motor type and load its preset gain set; the bank only reports preset 00 or 01 and keeps the stored gains.
// - keep-gains 1 makes auto setup use the written gains and leave them unchanged.
// - two signed 16-bit read-only analog readings in digits, resetting to zero.
// - in voltage mode 1024 digits mean 10 V.
// - in current mode 1024 digits mean 20 mA.
// - each channel's mode comes from its own bit of the analog control object.
// - control bit 0 selects channel 1, bit 1 channel 2; clear is voltage, set is current.
`timescale 1ns/100ps
`default_nettype none
`include "dpo_regs.svh"
module dpo_bank (
    input wire logic mclk,
    input wire logic rst_n,
    input wire dpo_pkg::dpo_acc_t acc,
    output dpo_pkg::dpo_rsp_t rsp,
    input wire logic switched_on,
    input wire logic [7:0] ctrl_duty,
    output logic [7:0] pwm_duty,
    input wire logic restart,
    input wire logic fw_invert_default,
    output logic field_inverted,
    output logic setup_needed,
    input wire logic setup_start,
    input wire logic motor_is_bldc,
    output logic setup_busy,
    output logic setup_done,
    output logic [1:0] setup_gain_preset,
    input wire logic ain1_vld,
    input wire logic [15:0] ain1_sample,
    input wire logic ain2_vld,
    input wire logic [15:0] ain2_sample,
    output logic [1:0] ain_current_mode,
    output logic [31:0] ain1_eng,
    output logic [31:0] ain2_eng
);
    ////////////////////////////////////////////////////////////////////////////
    // access decode
    wire logic acc_wr = acc.req && acc.wr;
    wire logic hit_gain = acc.index == `DPO_IDX_GAINS;
    wire logic hit_flag = acc.index == `DPO_IDX_FLAGS;
    wire logic hit_ain = acc.index == `DPO_IDX_ANALOG;
    wire logic hit_actl = acc.index == `DPO_IDX_ACTRL;
    // gain subindices 01..0A, grouped position/speed/current by subindex order
    wire logic gain_sub_ok = (acc.sub != `DPO_SUB_COUNT) && (acc.sub <= `DPO_GAIN_COUNT);
    wire logic flag_sub_ok = acc.sub <= `DPO_FLAG_COUNT;
    wire logic ain_sub_ok = acc.sub <= `DPO_AIN_COUNT;
    wire logic actl_sub_ok = acc.sub == `DPO_SUB_COUNT;
    wire logic wr_hold = acc_wr && hit_flag && acc.sub == `DPO_SUB_HOLD;
    wire logic wr_finv = acc_wr && hit_flag && acc.sub == `DPO_SUB_FINV;
    wire logic wr_keep = acc_wr && hit_flag && acc.sub == `DPO_SUB_KEEP;
    wire logic wr_actl = acc_wr && hit_actl && actl_sub_ok;
    // only 0 and 1 are legal for the boolean flags; -1 is also legal for the field override
    wire logic wval_bool = acc.wdata[7:0] == 8'h00 || acc.wdata[7:0] == 8'h01;
    wire logic wval_finv = wval_bool || acc.wdata[7:0] == 8'hFF;
    // read-only entries and counts refuse writes
    wire logic wr_ro = acc_wr && (hit_ain || (hit_flag && acc.sub == `DPO_SUB_COUNT) ||
                                  (hit_gain && acc.sub == `DPO_SUB_COUNT));
    wire logic bad_obj = !(hit_gain && (gain_sub_ok || acc.sub == `DPO_SUB_COUNT)) &&
                         !(hit_flag && flag_sub_ok) && !(hit_ain && ain_sub_ok) && !(hit_actl && actl_sub_ok);
    wire logic bad_val = (wr_hold && !wval_bool) || (wr_keep && !wval_bool) || (wr_finv && !wval_finv);

    ////////////////////////////////////////////////////////////////////////////
    // state
    logic [7:0] hold_r;
    logic [7:0] finv_r;
    logic [7:0] keep_r;
    logic [1:0] actl_r;
    logic [1:0] finv_live_r;
    logic finv_pend_r;
    logic setup_needed_r;
    logic [7:0] pwm_r;
    logic field_inv_r;
    logic [1:0] preset_r;
    dpo_pkg::dpo_setup_t setup_st_r;
    dpo_pkg::dpo_setup_t setup_st_nxt;
    dpo_pkg::dpo_rsp_t rsp_r;
    dpo_pkg::dpo_rsp_t rsp_nxt;
    logic rd_pend_r;
    logic setup_busy_r;
    logic setup_done_r;
    wire logic [31:0] gain_rdata;
    wire logic [15:0] ain1_dig;
    wire logic [15:0] ain2_dig;

    ////////////////////////////////////////////////////////////////////////////
    // gain set memory; auto setup writes nothing back, so stored gains survive it
    wire logic gain_we = acc_wr && hit_gain && gain_sub_ok;
    dpo_gain_mem u_gain (
        .mclk(mclk),
        .rst_n(rst_n),
        .we(gain_we),
        .waddr(acc.sub[3:0]),
        .wdata(acc.wdata),
        .raddr(acc.sub[3:0]),
        .rdata(gain_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // drive flags
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            hold_r <= 8'h00;
            finv_r <= 8'h00;
            keep_r <= 8'h00;
        end else begin
            if (wr_hold && wval_bool)
                hold_r <= acc.wdata[7:0];
            if (wr_finv && wval_finv)
                finv_r <= acc.wdata[7:0];
            if (wr_keep && wval_bool)
                keep_r <= acc.wdata[7:0];
        end
    end

    // stored override is latched into the live field setting only on restart
    wire logic [1:0] finv_dec = (finv_r == 8'h01) ? 2'(dpo_pkg::DPO_FINV_POSITIVE) :
                                (finv_r == 8'hFF) ? 2'(dpo_pkg::DPO_FINV_NEGATIVE) :
                                2'(dpo_pkg::DPO_FINV_DEFAULT);
    wire logic finv_changes = wr_finv && wval_finv && acc.wdata[7:0] != finv_r;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            finv_live_r <= 2'(dpo_pkg::DPO_FINV_DEFAULT);
            finv_pend_r <= 1'b0;
            setup_needed_r <= 1'b0;
        end else begin
            if (restart)
                finv_live_r <= finv_dec;
            // a write landing in the restart cycle stays pending: set wins
            finv_pend_r <= finv_changes || (finv_pend_r && !restart);
            // after a restart that applied a new override, setup must run again
            setup_needed_r <= (restart && finv_pend_r) ||
                              (setup_needed_r && setup_st_r != dpo_pkg::DPO_SETUP_DONE);
        end
    end

    wire logic inv_sel = (finv_live_r == 2'(dpo_pkg::DPO_FINV_POSITIVE)) ? 1'b0 :
                         (finv_live_r == 2'(dpo_pkg::DPO_FINV_NEGATIVE)) ? 1'b1 :
                         fw_invert_default;
    // holding flag 0 parks the bridge at half duty while switched on
    wire logic [7:0] pwm_nxt = (switched_on && hold_r == 8'h00) ? `DPO_PWM_HALF : ctrl_duty;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pwm_r <= `DPO_PWM_HALF;
            field_inv_r <= 1'b0;
        end else begin
            pwm_r <= pwm_nxt;
            field_inv_r <= inv_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // auto setup sequencing: one cycle run, preset chosen from keep flag and motor type
    always_comb begin
        setup_st_nxt = setup_st_r;
        case (setup_st_r)
            dpo_pkg::DPO_SETUP_IDLE: begin
                if (setup_start)
                    setup_st_nxt = dpo_pkg::DPO_SETUP_RUN;
            end
            dpo_pkg::DPO_SETUP_RUN: begin
                setup_st_nxt = dpo_pkg::DPO_SETUP_DONE;
            end
            dpo_pkg::DPO_SETUP_DONE: begin
                setup_st_nxt = dpo_pkg::DPO_SETUP_IDLE;
            end
            default: begin
                setup_st_nxt = dpo_pkg::DPO_SETUP_IDLE;
            end
        endcase
    end
    // preset code: 00 stepper preset, 01 bldc preset, 10 keep stored gains
    wire logic [1:0] preset_nxt = (keep_r == 8'h01) ? 2'b10 :
                                  (motor_is_bldc ? 2'b01 : 2'b00);
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            setup_st_r <= dpo_pkg::DPO_SETUP_IDLE;
            preset_r <= 2'b00;
            setup_busy_r <= 1'b0;
            setup_done_r <= 1'b0;
        end else begin
            setup_st_r <= setup_st_nxt;
            // flags taken from the next state track the state register cycle for cycle
            setup_busy_r <= setup_st_nxt == dpo_pkg::DPO_SETUP_RUN;
            setup_done_r <= setup_st_nxt == dpo_pkg::DPO_SETUP_DONE;
            if (setup_st_r == dpo_pkg::DPO_SETUP_RUN)
                preset_r <= preset_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // analog inputs and their mode control
    always_ff @(posedge mclk) begin
        if (!rst_n)
            actl_r <= 2'b00;
        else if (wr_actl)
            actl_r <= {acc.wdata[`DPO_AC_BIT_TWO], acc.wdata[`DPO_AC_BIT_ONE]};
    end
    wire logic analog_mode_select_one = actl_r[0];
    wire logic analog_mode_select_two = actl_r[1];
    dpo_ain_scale u_ain1 (
        .mclk(mclk),
        .rst_n(rst_n),
        .sample_vld(ain1_vld),
        .sample(ain1_sample),
        .mode_current(analog_mode_select_one),
        .digits(ain1_dig),
        .eng_value(ain1_eng)
    );
    dpo_ain_scale u_ain2 (
        .mclk(mclk),
        .rst_n(rst_n),
        .sample_vld(ain2_vld),
        .sample(ain2_sample),
        .mode_current(analog_mode_select_two),
        .digits(ain2_dig),
        .eng_value(ain2_eng)
    );

    ////////////////////////////////////////////////////////////////////////////
    // answer path; gain reads wait one cycle for the memory's registered output
    wire logic [31:0] flag_rd = (acc.sub == `DPO_SUB_COUNT) ? {24'h000000, `DPO_FLAG_COUNT} :
                                (acc.sub == `DPO_SUB_HOLD) ? {{24{hold_r[7]}}, hold_r} :
                                (acc.sub == `DPO_SUB_FINV) ? {{24{finv_r[7]}}, finv_r} :
                                {{24{keep_r[7]}}, keep_r};
    wire logic [31:0] ain_rd = (acc.sub == `DPO_SUB_COUNT) ? {24'h000000, `DPO_AIN_COUNT} :
                               (acc.sub == `DPO_SUB_AIN1) ? {{16{ain1_dig[15]}}, ain1_dig} :
                               {{16{ain2_dig[15]}}, ain2_dig};
    wire logic [31:0] direct_rd = hit_flag ? flag_rd :
                                  hit_ain ? ain_rd :
                                  hit_actl ? {30'h0, actl_r} :
                                  {24'h000000, `DPO_GAIN_COUNT};
    wire logic gain_rd = acc.req && !acc.wr && hit_gain && gain_sub_ok;
    wire logic acc_err = bad_obj || wr_ro || bad_val;
    always_comb begin
        rsp_nxt = '0;
        if (rd_pend_r) begin
            rsp_nxt.ack = 1'b1;
            rsp_nxt.rdata = gain_rdata;
        end else if (acc.req && !gain_rd) begin
            rsp_nxt.ack = 1'b1;
            rsp_nxt.err = acc_err;
            rsp_nxt.rdata = (acc.wr || acc_err) ? 32'h00000000 : direct_rd;
        end
    end
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rsp_r <= '0;
            rd_pend_r <= 1'b0;
        end else begin
            rsp_r <= rsp_nxt;
            rd_pend_r <= gain_rd && !rd_pend_r;
        end
    end

    assign rsp = rsp_r;
    assign pwm_duty = pwm_r;
    assign field_inverted = field_inv_r;
    assign setup_needed = setup_needed_r;
    assign setup_busy = setup_busy_r;
    assign setup_done = setup_done_r;
    assign setup_gain_preset = preset_r;
    assign ain_current_mode = actl_r;
endmodule
`default_nettype wire

// [core/dpo_regs.svh]
// offsets, field positions, reset values and scaling constants of the drive parameter bank
`ifndef DPO_REGS_SVH
`define DPO_REGS_SVH
// object indices and subindices
`define DPO_IDX_GAINS 16'h3210
`define DPO_IDX_FLAGS 16'h3212
`define DPO_IDX_ANALOG 16'h3220
`define DPO_IDX_ACTRL 16'h3221
`define DPO_SUB_COUNT 8'h00
`define DPO_SUB_POS_P 8'h01
`define DPO_SUB_POS_I 8'h02
`define DPO_SUB_SPD_P 8'h03
`define DPO_SUB_SPD_I 8'h04
`define DPO_SUB_TQ_I_CL 8'h08
`define DPO_SUB_TQ_P_OL 8'h09
`define DPO_SUB_TQ_I_OL 8'h0A
`define DPO_SUB_HOLD 8'h01
`define DPO_SUB_FINV 8'h02
`define DPO_SUB_KEEP 8'h03
`define DPO_SUB_AIN1 8'h01
`define DPO_SUB_AIN2 8'h02
// reset values
`define DPO_RST_TQ_I_CL 32'h00002EE0
`define DPO_RST_TQ_P_OL 32'h0003A980
`define DPO_RST_TQ_I_OL 32'h0000AFC8
`define DPO_GAIN_COUNT 8'h0A
`define DPO_FLAG_COUNT 8'h03
`define DPO_AIN_COUNT 8'h02
// analog control bits
`define DPO_AC_BIT_ONE 0
`define DPO_AC_BIT_TWO 1
// full scale: 1024 digits per 10 V or per 20 mA
`define DPO_AIN_FS_DIGITS 16'h0400
`define DPO_AIN_FS_MV 16'h2710
`define DPO_AIN_FS_UA 16'h4E20
// pwm half duty on an 8 bit duty word
`define DPO_PWM_HALF 8'h80
`endif

// [core/dpo_pkg.sv]
// types of the drive parameter bank
`default_nettype none
package dpo_pkg;
    typedef struct packed {
        logic req;
        logic wr;
        logic [15:0] index;
        logic [7:0] sub;
        logic [31:0] wdata;
    } dpo_acc_t;
    typedef struct packed {
        logic ack;
        logic err;
        logic [31:0] rdata;
    } dpo_rsp_t;
    typedef enum logic [1:0] {
        DPO_FINV_DEFAULT,
        DPO_FINV_POSITIVE,
        DPO_FINV_NEGATIVE
    } dpo_finv_t;
    typedef enum {
        DPO_SETUP_IDLE,
        DPO_SETUP_RUN,
        DPO_SETUP_DONE
    } dpo_setup_t;
endpackage
`default_nettype wire

// [core/dpo_gain_mem.sv]
// ten-entry gain set memory with registered read data
`timescale 1ns/100ps
`default_nettype none
`include "dpo_regs.svh"
module dpo_gain_mem (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic we,
    input wire logic [3:0] waddr,
    input wire logic [31:0] wdata,
    input wire logic [3:0] raddr,
    output logic [31:0] rdata
);
    logic [31:0] mem_r [1:10];
    logic [31:0] rst_val [1:10];
    assign rst_val[1] = 32'h00000800;
    assign rst_val[2] = 32'h00000000;
    assign rst_val[3] = 32'h00002EE0;
    assign rst_val[4] = 32'h0000001E;
    assign rst_val[5] = 32'h000668A0;
    assign rst_val[6] = 32'h00002EE0;
    assign rst_val[7] = 32'h000668A0;
    assign rst_val[8] = `DPO_RST_TQ_I_CL;
    assign rst_val[9] = `DPO_RST_TQ_P_OL;
    assign rst_val[10] = `DPO_RST_TQ_I_OL;
    genvar g;
    generate
        for (g = 1; g <= 10; g++) begin : g_ent
            always_ff @(posedge mclk) begin
                if (!rst_n)
                    mem_r[g] <= rst_val[g];
                else if (we && waddr == 4'(g))
                    mem_r[g] <= wdata;
            end
        end
    endgenerate
    // out-of-range addresses read zero
    wire logic in_range = (raddr != 4'h0) && (raddr <= 4'hA);
    always_ff @(posedge mclk) begin
        if (!rst_n)
            rdata <= 32'h00000000;
        else
            rdata <= in_range ? mem_r[raddr] : 32'h00000000;
    end
endmodule
`default_nettype wire

// [core/dpo_ain_scale.sv]
// analog reading register and engineering-unit scaling for one channel
`timescale 1ns/100ps
`default_nettype none
`include "dpo_regs.svh"
module dpo_ain_scale (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic sample_vld,
    input wire logic [15:0] sample,
    input wire logic mode_current,
    output logic [15:0] digits,
    output logic [31:0] eng_value
);
    logic signed [15:0] dig_r;
    logic signed [31:0] eng_nxt;
    wire logic signed [31:0] fs = mode_current ? {16'h0000, `DPO_AIN_FS_UA} : {16'h0000, `DPO_AIN_FS_MV};
    // divide by 1024 is a shift; truncates toward minus infinity for negative readings
    assign eng_nxt = (32'(dig_r) * fs) >>> 10;
    always_ff @(posedge mclk) begin
        if (!rst_n)
            dig_r <= 16'sh0000;
        else if (sample_vld)
            dig_r <= sample;
    end
    always_ff @(posedge mclk) begin
        if (!rst_n)
            eng_value <= 32'h00000000;
        else
            eng_value <= eng_nxt;
    end
    assign digits = dig_r;
endmodule
`default_nettype wire

// [test/dpo_bank_chk.sv]
// concurrent checks on the access port, pwm, field and setup outputs of the bank
`timescale 1ns/100ps
`default_nettype none
module dpo_bank_chk (
    input wire logic mclk,
    input wire logic rst_n,
    input wire dpo_pkg::dpo_acc_t acc,
    input wire dpo_pkg::dpo_rsp_t rsp,
    input wire logic switched_on,
    input wire logic [7:0] ctrl_duty,
    input wire logic [7:0] pwm_duty,
    input wire logic restart,
    input wire logic fw_invert_default,
    input wire logic field_inverted,
    input wire logic setup_busy,
    input wire logic setup_done
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////
    // shadow of the holding flag, rebuilt from accepted writes only
    logic hold_r;
    logic hold_wr_r;
    logic hold_bit_r;
    wire gain_rd = acc.req && !acc.wr && acc.index == 16'h3210 && acc.sub inside {[8'h01:8'h0A]};
    wire hold_wr = acc.req && acc.wr && acc.index == 16'h3212 && acc.sub == 8'h01;
    wire quiet = !acc.req && !rsp.ack;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            hold_r <= 1'b0;
            hold_wr_r <= 1'b0;
            hold_bit_r <= 1'b0;
        end else begin
            hold_wr_r <= hold_wr;
            hold_bit_r <= acc.wdata[0];
            if (rsp.ack && !rsp.err && hold_wr_r) begin
                hold_r <= hold_bit_r;
            end
        end
    end
    ////////////////////////////////////////
    a_plain_answer: assert property (acc.req && !gain_rd |=> rsp.ack)
        else $error("access not answered in one cycle");
    a_gain_answer: assert property (gain_rd |=> !rsp.ack ##1 (rsp.ack && !rsp.err))
        else $error("gain read not answered in two cycles");
    a_ack_pulse: assert property (rsp.ack |=> !rsp.ack)
        else $error("ack longer than one cycle");
    a_err_no_data: assert property (rsp.ack && rsp.err |-> rsp.rdata == 32'h00000000)
        else $error("refused access returned data");
    a_flag_refuse: assert property (hold_wr && acc.wdata == 32'h00000002 |=> rsp.ack && rsp.err)
        else $error("out of range flag write accepted");
    a_ro_refuse: assert property (acc.req && acc.wr && acc.index == 16'h3220 |=> rsp.err)
        else $error("write to analog readings accepted");
    a_half_duty: assert property (switched_on && !hold_r && quiet |=> pwm_duty == 8'h80)
        else $error("pwm not at half duty");
    a_duty_follow: assert property (switched_on && hold_r && quiet |=> pwm_duty == $past(ctrl_duty))
        else $error("pwm not following controller");
    a_field_stable: assert property (!restart && !$past(restart) && $stable(fw_invert_default)
        |=> $stable(field_inverted))
        else $error("field direction changed without restart");
    a_setup_done: assert property (setup_busy |=> setup_done && !setup_busy)
        else $error("setup did not finish after busy");
    a_done_cause: assert property (setup_done |-> $past(setup_busy))
        else $error("setup done without busy");
endmodule
`default_nettype wire

// [test/dpo_master.sv]
// fieldbus master model issuing single object accesses to the bank
`timescale 1ns/100ps
`default_nettype none
module dpo_master (
    input wire logic mclk,
    output dpo_pkg::dpo_acc_t acc,
    input wire dpo_pkg::dpo_rsp_t rsp
);
    initial acc = '0;
    ////////////////////////////////////////
    // one access in flight; the answer is taken at the rising edge that sees ack high
    task automatic xfer(input logic w, input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        int n;
        q = 'x;
        e = 1'bx;
        n = 0;
        @(posedge mclk);
        acc <= '{req: 1'b1, wr: w, index: ix, sub: sb, wdata: d};
        @(posedge mclk);
        acc.req <= 1'b0;
        do begin
            @(posedge mclk);
            n++;
        end while (rsp.ack !== 1'b1 && n < 8);
        if (rsp.ack === 1'b1) begin
            q = rsp.rdata;
            e = rsp.err;
        end
    endtask
endmodule
`default_nettype wire

// [test/dpo_bank_tb.sv]
// self-checking bench for the drive parameter bank
`timescale 1ns/100ps
`default_nettype none
module dpo_bank_tb;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic switched_on = 1'b0;
    logic [7:0] ctrl_duty = 8'h3C;
    logic restart = 1'b0;
    logic fw_invert_default = 1'b0;
    logic setup_start = 1'b0;
    logic motor_is_bldc = 1'b1;
    logic ain1_vld = 1'b0;
    logic [15:0] ain1_sample = 16'h0000;
    logic ain2_vld = 1'b0;
    logic [15:0] ain2_sample = 16'h0000;
    dpo_pkg::dpo_acc_t acc;
    dpo_pkg::dpo_rsp_t rsp;
    logic [7:0] pwm_duty;
    logic field_inverted, setup_needed, setup_busy, setup_done;
    logic [1:0] setup_gain_preset;
    logic [1:0] ain_current_mode;
    logic [31:0] ain1_eng, ain2_eng, q;
    logic e;
    int mismatches = 0;
    int samples_checked = 0;
    always #10 mclk = ~mclk;
    dpo_master u_master (.mclk(mclk), .acc(acc), .rsp(rsp));
    dpo_bank dut (.mclk(mclk), .rst_n(rst_n), .acc(acc), .rsp(rsp), .switched_on(switched_on),
        .ctrl_duty(ctrl_duty), .pwm_duty(pwm_duty), .restart(restart), .fw_invert_default(fw_invert_default),
        .field_inverted(field_inverted), .setup_needed(setup_needed), .setup_start(setup_start),
        .motor_is_bldc(motor_is_bldc), .setup_busy(setup_busy), .setup_done(setup_done),
        .setup_gain_preset(setup_gain_preset), .ain1_vld(ain1_vld), .ain1_sample(ain1_sample),
        .ain2_vld(ain2_vld), .ain2_sample(ain2_sample), .ain_current_mode(ain_current_mode),
        .ain1_eng(ain1_eng), .ain2_eng(ain2_eng));
    ////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd(input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] exp);
        u_master.xfer(1'b0, ix, sb, 32'h0, q, e);
        chk($sformatf("read %h:%h", ix, sb), q, exp);
        if (e === 1'bx) tally_and_finish;
    endtask
    task automatic wr(input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] d, input logic ex);
        u_master.xfer(1'b1, ix, sb, d, q, e);
        chk($sformatf("write error %h:%h", ix, sb), {31'h0, e}, {31'h0, ex});
        if (e === 1'bx) tally_and_finish;
    endtask
    // one-cycle strobe: 0 restart, 1 setup start, 2 and 3 analog samples
    task automatic pulse(input int sel);
        @(posedge mclk);
        restart <= (sel == 0);
        setup_start <= (sel == 1);
        ain1_vld <= (sel == 2);
        ain2_vld <= (sel == 3);
        @(posedge mclk);
        {restart, setup_start, ain1_vld, ain2_vld} <= 4'h0;
        repeat (4) @(negedge mclk);
    endtask
    task automatic run_setup(input logic [1:0] exp);
        int n;
        n = 0;
        @(posedge mclk);
        setup_start <= 1'b1;
        @(posedge mclk);
        setup_start <= 1'b0;
        do begin
            @(negedge mclk);
            n++;
        end while (setup_done !== 1'b1 && n < 20);
        chk("setup done", {31'h0, setup_done}, 32'h1);
        chk("setup preset", {30'h0, setup_gain_preset}, {30'h0, exp});
        if (setup_done !== 1'b1) tally_and_finish;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // a hang costs a mismatch instead of an endless run
    initial begin
        #1000000;
        mismatches++;
        tally_and_finish;
    end
    ////////////////////////////////////////
    initial begin
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        rd(16'h3210, 8'h08, 32'h00002EE0);
        rd(16'h3210, 8'h09, 32'h0003A980);
        rd(16'h3210, 8'h0A, 32'h0000AFC8);
        rd(16'h3210, 8'h00, 32'h0000000A);
        rd(16'h3212, 8'h00, 32'h00000003);
        for (int i = 1; i < 4; i++) rd(16'h3212, i[7:0], 32'h0);
        rd(16'h3220, 8'h00, 32'h00000002);
        for (int i = 1; i < 3; i++) rd(16'h3220, i[7:0], 32'h0);
        // every gain entry holds its own value back to back
        for (int i = 1; i < 11; i++) wr(16'h3210, i[7:0], 32'h5A000000 | i, 1'b0);
        for (int i = 1; i < 11; i++) rd(16'h3210, i[7:0], 32'h5A000000 | i);
        wr(16'h3210, 8'h0B, 32'h1, 1'b1);
        @(posedge mclk);
        switched_on <= 1'b1;
        repeat (3) @(negedge mclk);
        chk("pwm duty", {24'h0, pwm_duty}, 32'h80);
        wr(16'h3212, 8'h01, 32'h1, 1'b0);
        repeat (3) @(negedge mclk);
        chk("pwm duty", {24'h0, pwm_duty}, 32'h3C);
        wr(16'h3212, 8'h01, 32'h2, 1'b1);
        rd(16'h3212, 8'h01, 32'h1);
        wr(16'h3212, 8'h01, 32'h0, 1'b0);
        repeat (3) @(negedge mclk);
        chk("pwm duty", {24'h0, pwm_duty}, 32'h80);
        // field override waits for restart; setup is then rerun by the bench's run_setup strobe on setup_start
        wr(16'h3212, 8'h02, 32'hFF, 1'b0);
        rd(16'h3212, 8'h02, 32'hFFFFFFFF);
        wr(16'h3212, 8'h02, 32'h5, 1'b1);
        chk("field before restart", {31'h0, field_inverted}, 32'h0);
        pulse(0);
        chk("field inverted", {31'h0, field_inverted}, 32'h1);
        chk("setup needed", {31'h0, setup_needed}, 32'h1);
        run_setup(2'b01);
        // the flag drops on the edge that leaves done
        @(negedge mclk);
        chk("setup needed", {31'h0, setup_needed}, 32'h0);
        wr(16'h3212, 8'h02, 32'h1, 1'b0);
        pulse(0);
        chk("field inverted", {31'h0, field_inverted}, 32'h0);
        wr(16'h3212, 8'h02, 32'h0, 1'b0);
        fw_invert_default <= 1'b1;
        pulse(0);
        chk("field inverted", {31'h0, field_inverted}, 32'h1);
        @(posedge mclk);
        motor_is_bldc <= 1'b0;
        run_setup(2'b00);
        wr(16'h3212, 8'h03, 32'h1, 1'b0);
        wr(16'h3210, 8'h08, 32'h12345678, 1'b0);
        run_setup(2'b10);
        rd(16'h3210, 8'h08, 32'h12345678);
        // analog: plus and minus full scale, voltage then current
        ain1_sample <= 16'h0400;
        ain2_sample <= 16'hFC00;
        pulse(2);
        pulse(3);
        rd(16'h3220, 8'h01, 32'h00000400);
        rd(16'h3220, 8'h02, 32'hFFFFFC00);
        chk("ain1 eng", ain1_eng, 32'h00002710);
        chk("ain2 eng", ain2_eng, 32'hFFFFD8F0);
        wr(16'h3221, 8'h00, 32'h3, 1'b0);
        rd(16'h3221, 8'h00, 32'h3);
        chk("mode", {30'h0, ain_current_mode}, 32'h3);
        pulse(2);
        pulse(3);
        chk("ain1 eng", ain1_eng, 32'h00004E20);
        chk("ain2 eng", ain2_eng, 32'hFFFFB1E0);
        wr(16'h3221, 8'h00, 32'h2, 1'b0);
        pulse(2);
        chk("ain1 eng", ain1_eng, 32'h00002710);
        wr(16'h3220, 8'h01, 32'h1, 1'b1);
        rd(16'h3220, 8'h01, 32'h00000400);
        tally_and_finish;
    end
endmodule
bind dpo_bank dpo_bank_chk u_chk (.mclk(mclk), .rst_n(rst_n), .acc(acc), .rsp(rsp), .switched_on(switched_on),
    .ctrl_duty(ctrl_duty), .pwm_duty(pwm_duty), .restart(restart), .fw_invert_default(fw_invert_default),
    .field_inverted(field_inverted), .setup_busy(setup_busy), .setup_done(setup_done));
`default_nettype wire
